// ### hw/second_level_event_manager.sv
/*
 Second-level event manager: per-peripheral flag slices, the two
 non-maskable sources (crystal loss with clock fallback, watchdog) and
 the bus fault cause recorder.
 Assumes peripheral events and software strobes are synchronous to clk;
 the crystal beat and clock switch acknowledge arrive asynchronously.
*/
`timescale 1ns/1ps
module second_level_event_manager import event_manager_pkg::*; #(
	parameter int unsigned WDOG_CYCLES = WDOG_TIMEOUT_CYCLES
) (
	// Clock and reset
	input logic clk,
	input logic resetn,
	// Peripheral events
	input logic [N_PERIPH-1:0][FLAG_W-1:0] periph_event,
	// Software strobes
	input logic [N_PERIPH-1:0] cfg_wr,
	input logic [N_PERIPH-1:0][FLAG_W-1:0] cfg_wdata,
	input logic [N_PERIPH-1:0][FLAG_W-1:0] flag_clr_bits,
	input logic [N_PERIPH-1:0] miss_clr,
	input logic [NMI_W-1:0] nmi_clr,
	input logic [CAUSE_W-1:0] cause_clr,
	// Clock monitor
	input logic sclk_on_xtal,
	input logic xtal_beat,
	input logic clk_switch_done,
	// Watchdog
	input logic wdog_active,
	input logic wdog_restart,
	// Observed bus access
	input access_t bus_access,
	// Peripheral state and requests
	output logic [N_PERIPH-1:0][FLAG_W-1:0] event_pending_flags,
	output logic [N_PERIPH-1:0][FLAG_W-1:0] event_enable_mask,
	output logic [N_PERIPH-1:0] miss_flags,
	output logic [N_PERIPH-1:0] periph_irq,
	// Non-maskable request and clock fallback
	output logic [NMI_W-1:0] nmi_flags,
	output logic nmi_req,
	output logic rc_clk_sel,
	// Bus faults
	output logic [CAUSE_W-1:0] bus_fault_cause_reg,
	output logic bus_fault_req,
	output logic hard_fault_req
);
	localparam logic [WDOG_CNT_W-1:0] WDOG_LAST =
		WDOG_CNT_W'(WDOG_CYCLES - 1);

	top_state_t s_q, s_d;
	logic xtal_edge;
	logic xtal_lost;
	logic xtal_event;
	logic wdog_hit;

	// ****************************************************
	// Crystal activity
	// ****************************************************
	// Edges are taken from the second and third stages only
	assign xtal_edge = s_q.xtal_sync[2] ^ s_q.xtal_sync[1];
	assign xtal_lost = s_q.xtal_st == XTAL_RUN && sclk_on_xtal &&
		!xtal_edge && s_q.xtal_cnt == XTAL_LAST;

	// ****************************************************
	// Next state
	// ****************************************************
	always_comb begin
		s_d = s_q;
		xtal_event = 1'b0;
		wdog_hit = 1'b0;
		s_d.xtal_sync = {s_q.xtal_sync[1:0], xtal_beat};
		s_d.done_sync = {s_q.done_sync[0], clk_switch_done};

		case (s_q.xtal_st)
			XTAL_RUN: begin
				if (xtal_edge) begin
					s_d.xtal_cnt = 8'h00;
				end else if (s_q.xtal_cnt != XTAL_LAST) begin
					s_d.xtal_cnt = s_q.xtal_cnt + 8'h01;
				end
				// Fall back without waiting for software
				if (xtal_lost) begin
					s_d.rc_sel = 1'b1;
					s_d.xtal_st = XTAL_SWITCH;
				end
			end
			XTAL_SWITCH: begin
				// Flag only once the clock mux reports the switch
				if (s_q.done_sync[1]) begin
					xtal_event = 1'b1;
					s_d.xtal_st = XTAL_FAILED;
				end
			end
			XTAL_FAILED: begin
				// Stays on the RC clock until reset
				s_d.rc_sel = 1'b1;
			end
			default: begin
				s_d.xtal_st = XTAL_RUN;
			end
		endcase

		// Watchdog counts while active; saturates so it fires once
		if (!wdog_active || wdog_restart) begin
			s_d.wdog_cnt = 27'h000_0000;
		end else if (s_q.wdog_cnt != WDOG_CNT_W'(WDOG_CYCLES)) begin
			s_d.wdog_cnt = s_q.wdog_cnt + 27'h000_0001;
			wdog_hit = s_q.wdog_cnt == WDOG_LAST;
		end

		// Set wins over a same-cycle clear
		s_d.nmi_flags = s_q.nmi_flags & ~nmi_clr;
		s_d.nmi_flags[NMI_XTAL] = s_d.nmi_flags[NMI_XTAL] | xtal_event;
		s_d.nmi_flags[NMI_WDOG] = s_d.nmi_flags[NMI_WDOG] | wdog_hit;
		s_d.nmi = |s_d.nmi_flags;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= TOP_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign nmi_flags = s_q.nmi_flags;
	assign nmi_req = s_q.nmi;
	assign rc_clk_sel = s_q.rc_sel;

	// ****************************************************
	// Peripheral slices
	// ****************************************************
	for (genvar i = 0; i < N_PERIPH; i++) begin : g_slice
		event_slice u_slice (
			.clk(clk),
			.resetn(resetn),
			.event_in(periph_event[i]),
			.cfg_wr(cfg_wr[i]),
			.cfg_wdata(cfg_wdata[i]),
			.clr_bits(flag_clr_bits[i]),
			.miss_clr(miss_clr[i]),
			.flags(event_pending_flags[i]),
			.mask(event_enable_mask[i]),
			.miss(miss_flags[i]),
			.irq(periph_irq[i])
		);

		property p_flag_set;
			@(posedge clk) disable iff (!resetn)
			periph_event[i] != 16'h0000 |=>
				(event_pending_flags[i] & $past(periph_event[i])) ==
				$past(periph_event[i]);
		endproperty
		a_flag_set: assert property (p_flag_set)
			else $error("event did not set its flag");

		property p_flag_clr;
			@(posedge clk) disable iff (!resetn)
			flag_clr_bits[i] != 16'h0000 |=>
				(event_pending_flags[i] & $past(flag_clr_bits[i]) &
				~$past(periph_event[i])) == 16'h0000;
		endproperty
		a_flag_clr: assert property (p_flag_clr)
			else $error("write one did not clear flag");

		property p_flag_keep;
			@(posedge clk) disable iff (!resetn)
			event_pending_flags[i] != 16'h0000 |=>
				($past(event_pending_flags[i]) &
				~$past(flag_clr_bits[i]) &
				~event_pending_flags[i]) == 16'h0000;
		endproperty
		a_flag_keep: assert property (p_flag_keep)
			else $error("flag lost without a clear");

		property p_mask_load;
			@(posedge clk) disable iff (!resetn)
			cfg_wr[i] |=> event_enable_mask[i] == $past(cfg_wdata[i]);
		endproperty
		a_mask_load: assert property (p_mask_load)
			else $error("enable mask not loaded");

		property p_irq_level;
			@(posedge clk) disable iff (!resetn)
			periph_irq[i] ==
				|(event_pending_flags[i] & event_enable_mask[i]);
		endproperty
		a_irq_level: assert property (p_irq_level)
			else $error("request differs from enabled flags");

		property p_irq_hold;
			@(posedge clk) disable iff (!resetn)
			periph_irq[i] && !cfg_wr[i] &&
				(flag_clr_bits[i] & event_pending_flags[i] &
				event_enable_mask[i]) == 16'h0000 |=>
				periph_irq[i];
		endproperty
		a_irq_hold: assert property (p_irq_hold)
			else $error("request dropped with flags pending");

		property p_late_enable;
			@(posedge clk) disable iff (!resetn)
			cfg_wr[i] && (cfg_wdata[i] & event_pending_flags[i] &
				~flag_clr_bits[i]) != 16'h0000 |=> periph_irq[i];
		endproperty
		a_late_enable: assert property (p_late_enable)
			else $error("pending flag not propagated on enable");

		property p_miss_set;
			@(posedge clk) disable iff (!resetn)
			(periph_event[i] & event_enable_mask[i] &
				event_pending_flags[i]) != 16'h0000 |=> miss_flags[i];
		endproperty
		a_miss_set: assert property (p_miss_set)
			else $error("repeated event not marked missed");

		property p_miss_clr;
			@(posedge clk) disable iff (!resetn)
			miss_clr[i] && (periph_event[i] & event_enable_mask[i] &
				event_pending_flags[i]) == 16'h0000 |=> !miss_flags[i];
		endproperty
		a_miss_clr: assert property (p_miss_clr)
			else $error("missed indicator not cleared");
	end

	// ****************************************************
	// Bus fault causes
	// ****************************************************
	bus_fault_recorder u_fault (
		.clk(clk),
		.resetn(resetn),
		.acc(bus_access),
		.cause_clr(cause_clr),
		.cause(bus_fault_cause_reg),
		.fault(bus_fault_req),
		.hard(hard_fault_req)
	);

	// ****************************************************
	// Checks
	// ****************************************************
	property p_nmi_src;
		@(posedge clk) disable iff (!resetn)
		nmi_req == (nmi_flags[NMI_XTAL] || nmi_flags[NMI_WDOG]);
	endproperty
	a_nmi_src: assert property (p_nmi_src)
		else $error("NMI not tied to its two sources");

	property p_xtal_switch;
		@(posedge clk) disable iff (!resetn)
		xtal_lost |=> rc_clk_sel && s_q.xtal_st == XTAL_SWITCH &&
			!nmi_flags[NMI_XTAL];
	endproperty
	a_xtal_switch: assert property (p_xtal_switch)
		else $error("crystal loss did not select RC clock");

	property p_xtal_flag;
		@(posedge clk) disable iff (!resetn)
		$rose(nmi_flags[NMI_XTAL]) |->
			rc_clk_sel && $past(s_q.xtal_st) == XTAL_SWITCH;
	endproperty
	a_xtal_flag: assert property (p_xtal_flag)
		else $error("crystal flag before clock switch");

	property p_wdog_fire;
		@(posedge clk) disable iff (!resetn)
		$rose(nmi_flags[NMI_WDOG]) |-> $past(s_q.wdog_cnt) == WDOG_LAST;
	endproperty
	a_wdog_fire: assert property (p_wdog_fire)
		else $error("watchdog flag at wrong count");

	property p_wdog_restart;
		@(posedge clk) disable iff (!resetn)
		wdog_restart |=> s_q.wdog_cnt == 27'h000_0000 &&
			!$rose(nmi_flags[NMI_WDOG]);
	endproperty
	a_wdog_restart: assert property (p_wdog_restart)
		else $error("watchdog restart ignored");

	property p_width;
		@(posedge clk) disable iff (!resetn)
		bus_access.valid && bus_access.apb_target &&
			bus_access.size != SIZE_WORD |=>
			bus_fault_cause_reg[CAUSE_WIDTH] && bus_fault_req;
	endproperty
	a_width: assert property (p_width)
		else $error("narrow access not flagged");

	property p_protect;
		@(posedge clk) disable iff (!resetn)
		bus_access.valid && bus_access.write &&
			!bus_access.privileged && bus_access.prot_ram |=>
			bus_fault_cause_reg[CAUSE_PROT] && bus_fault_req;
	endproperty
	a_protect: assert property (p_protect)
		else $error("unprivileged write not flagged");

	property p_reserved;
		@(posedge clk) disable iff (!resetn)
		bus_access.valid && bus_access.past_mem_top |=>
			bus_fault_cause_reg[CAUSE_RSVD] && bus_fault_req;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved address not flagged");

	property p_missed;
		@(posedge clk) disable iff (!resetn)
		bus_fault_req && $past(bus_fault_cause_reg) != 4'h0 |->
			hard_fault_req && bus_fault_cause_reg[CAUSE_MISS];
	endproperty
	a_missed: assert property (p_missed)
		else $error("second fault not marked missed");

	property p_reset_quiet;
		@(posedge clk) disable iff (!resetn)
		$rose(resetn) |-> periph_irq == '0 && !nmi_req &&
			miss_flags == '0;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("request active after reset");
endmodule

// ### hw/event_manager_pkg.sv
/*
 Constants, carrier structs and state types shared by the event manager,
 its per-peripheral slices and the bus fault recorder.
 Assumes one 40 MHz system clock and an active-low asynchronous reset.
*/
package event_manager_pkg;

	// ****************************************************
	// Sizes
	// ****************************************************
	localparam int N_PERIPH = 17;
	localparam int FLAG_W = 16;
	localparam int NMI_W = 2;
	localparam int CAUSE_W = 4;
	localparam int XTAL_CNT_W = 8;
	localparam int WDOG_CNT_W = 27;

	// ****************************************************
	// Field positions
	// ****************************************************
	localparam int NMI_XTAL = 0;
	localparam int NMI_WDOG = 1;
	localparam int CAUSE_WIDTH = 0;
	localparam int CAUSE_PROT = 1;
	localparam int CAUSE_RSVD = 2;
	localparam int CAUSE_MISS = 3;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	// ****************************************************
	// Timing
	// ****************************************************
	localparam int CLK_KHZ = 40000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int WDOG_TIMEOUT_MS = 1792;
	localparam int WDOG_TIMEOUT_CYCLES = WDOG_TIMEOUT_MS * CLK_KHZ;
	localparam int XTAL_TIMEOUT_NS = 2000;
	localparam int XTAL_TIMEOUT_CYCLES =
		(XTAL_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [XTAL_CNT_W-1:0] XTAL_LAST =
		XTAL_CNT_W'(XTAL_TIMEOUT_CYCLES - 1);

	// ****************************************************
	// Types
	// ****************************************************
	typedef logic [FLAG_W-1:0] flag_vec_t;
	typedef enum logic [1:0] {XTAL_RUN, XTAL_SWITCH, XTAL_FAILED} xtal_st_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic privileged;
		logic [1:0] size;
		logic [1:0] addr_lo;
		logic apb_target;
		logic sys_periph;
		logic prot_ram;
		logic [11:0] blk_off;
		logic [11:0] last_reg_off;
		logic past_mem_top;
	} access_t;

	typedef struct packed {
		flag_vec_t flags;
		flag_vec_t mask;
		logic miss;
		logic irq;
	} slice_state_t;

	typedef struct packed {
		logic [CAUSE_W-1:0] cause;
		logic fault;
		logic hard;
	} fault_state_t;

	typedef struct packed {
		logic [2:0] xtal_sync;
		logic [1:0] done_sync;
		xtal_st_t xtal_st;
		logic [XTAL_CNT_W-1:0] xtal_cnt;
		logic rc_sel;
		logic [WDOG_CNT_W-1:0] wdog_cnt;
		logic [NMI_W-1:0] nmi_flags;
		logic nmi;
	} top_state_t;

	// ****************************************************
	// Values after reset
	// ****************************************************
	localparam slice_state_t SLICE_RST = '{
		flags: 16'h0000, mask: 16'h0000, miss: 1'b0, irq: 1'b0};
	localparam fault_state_t FAULT_RST = '{
		cause: 4'h0, fault: 1'b0, hard: 1'b0};
	localparam top_state_t TOP_RST = '{
		xtal_sync: 3'h0, done_sync: 2'h0, xtal_st: XTAL_RUN,
		xtal_cnt: 8'h00, rc_sel: 1'b0, wdog_cnt: 27'h000_0000,
		nmi_flags: 2'h0, nmi: 1'b0};

endpackage

// ### hw/event_slice.sv
/*
 One peripheral's flag, enable mask and missed indicator, with its
 level request to the top-level controller.
 Assumes events and software strobes come from logic on clk.
*/
`timescale 1ns/1ps
module event_slice import event_manager_pkg::*; (
	// Clock and reset
	input logic clk,
	input logic resetn,
	// Events and software strobes
	input flag_vec_t event_in,
	input logic cfg_wr,
	input flag_vec_t cfg_wdata,
	input flag_vec_t clr_bits,
	input logic miss_clr,
	// State
	output flag_vec_t flags,
	output flag_vec_t mask,
	output logic miss,
	output logic irq
);
	slice_state_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (cfg_wr) begin
			s_d.mask = cfg_wdata;
		end
		// Set wins over a same-cycle clear
		s_d.flags = (s_q.flags & ~clr_bits) | event_in;
		s_d.miss = (s_q.miss & ~miss_clr) |
			(|(event_in & s_q.mask & s_q.flags));
		s_d.irq = |(s_d.flags & s_d.mask);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= SLICE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign flags = s_q.flags;
	assign mask = s_q.mask;
	assign miss = s_q.miss;
	assign irq = s_q.irq;
endmodule

// ### hw/bus_fault_recorder.sv
/*
 Classifies observed bus accesses into fault causes and keeps them as
 sticky bits, with bus fault and hard fault pulses.
 Assumes the access descriptor is valid for one clk cycle per access.
*/
`timescale 1ns/1ps
module bus_fault_recorder import event_manager_pkg::*; (
	// Clock and reset
	input logic clk,
	input logic resetn,
	// Access and software clear
	input access_t acc,
	input logic [CAUSE_W-1:0] cause_clr,
	// Results
	output logic [CAUSE_W-1:0] cause,
	output logic fault,
	output logic hard
);
	fault_state_t s_q, s_d;
	logic [CAUSE_W-1:0] hit;
	logic second;

	always_comb begin
		s_d = s_q;
		hit = '0;
		hit[CAUSE_WIDTH] = acc.valid && acc.apb_target &&
			(acc.size != SIZE_WORD || acc.addr_lo != 2'h0);
		hit[CAUSE_PROT] = acc.valid && acc.write && !acc.privileged &&
			(acc.sys_periph || acc.prot_ram);
		hit[CAUSE_RSVD] = acc.valid && ((acc.apb_target &&
			acc.blk_off > acc.last_reg_off) || acc.past_mem_top);
		// A cause already held makes this one a second fault
		second = (|hit) && (|s_q.cause);
		hit[CAUSE_MISS] = second;
		s_d.cause = (s_q.cause & ~cause_clr) | hit;
		s_d.fault = |hit;
		s_d.hard = second;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= FAULT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign cause = s_q.cause;
	assign fault = s_q.fault;
	assign hard = s_q.hard;
endmodule

// ### dv/xtal_source_model.sv
/*
 Behavioural crystal beat source and clock mux acknowledge.
 Assumes the bench starts and stops the crystal through run.
*/
`timescale 1ns/1ps
module xtal_source_model #(
	parameter int BEAT_NS = 50,
	parameter int SWITCH_NS = 250
) (
	// Control
	input wire logic resetn,
	input wire logic run,
	input wire logic rc_clk_sel,
	// Towards the event manager
	output logic xtal_beat,
	output logic clk_switch_done
);
	// ****************************************************
	// Crystal beat, frozen while stopped
	// ****************************************************
	initial xtal_beat = 1'b0;
	always begin
		#(BEAT_NS);
		if (run) begin
			xtal_beat = ~xtal_beat;
		end
	end

	// ****************************************************
	// Mux reports RC selected some time after the request
	// ****************************************************
	initial clk_switch_done = 1'b0;
	always @(rc_clk_sel or resetn) begin
		if (!resetn || !rc_clk_sel) begin
			clk_switch_done = 1'b0;
		end else begin
			#(SWITCH_NS);
			clk_switch_done = 1'b1;
		end
	end
endmodule

// ### dv/second_level_event_manager_test.sv
/*
 Self-checking bench for the second-level event manager.
 Assumes a 40 MHz clock and a shortened watchdog count of 20.
*/
`timescale 1ns/1ps
module second_level_event_manager_test import event_manager_pkg::*;;
	// ****************************************************
	// Stimulus and results
	// ****************************************************
	typedef struct {int kind; int due; logic [65:0] v;} note_t;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [N_PERIPH-1:0][FLAG_W-1:0] ev = '0, wdat = '0, fclr = '0;
	logic [N_PERIPH-1:0][FLAG_W-1:0] pflags, pmask;
	logic [N_PERIPH-1:0] cwr = '0, mclr = '0, missv, irqv;
	logic [NMI_W-1:0] nclr = '0, nflags;
	logic [CAUSE_W-1:0] cclr = '0, cause;
	logic son = 1'b0, wact = 1'b0, wrst = 1'b0, run = 1'b1;
	logic beat, sdone, nreq, rcsel, freq, hreq;
	access_t acc = '0;
	note_t q[$];
	int cyc = 0, errors = 0, comparisons = 0, p = 0, n;
	integer seed = 32'h0000_175d;

	initial begin
		forever #12.5 clk = ~clk;
	end

	second_level_event_manager #(.WDOG_CYCLES(20)) second_level_event_manager_i (
		.clk(clk), .resetn(resetn), .periph_event(ev), .cfg_wr(cwr),
		.cfg_wdata(wdat), .flag_clr_bits(fclr), .miss_clr(mclr),
		.nmi_clr(nclr), .cause_clr(cclr), .sclk_on_xtal(son),
		.xtal_beat(beat), .clk_switch_done(sdone), .wdog_active(wact),
		.wdog_restart(wrst), .bus_access(acc),
		.event_pending_flags(pflags), .event_enable_mask(pmask),
		.miss_flags(missv), .periph_irq(irqv), .nmi_flags(nflags),
		.nmi_req(nreq), .rc_clk_sel(rcsel), .bus_fault_cause_reg(cause),
		.bus_fault_req(freq), .hard_fault_req(hreq));

	xtal_source_model xtal_source_model_i (.resetn(resetn), .run(run),
		.rc_clk_sel(rcsel), .xtal_beat(beat), .clk_switch_done(sdone));

	// ****************************************************
	// Notes and comparisons
	// ****************************************************
	task automatic note(int k, int d, logic [65:0] v);
		q.push_back('{k, cyc + d, v});
	endtask

	task automatic chk(logic [65:0] got, logic [65:0] v, string m);
		comparisons++;
		if (got !== v) begin
			errors++;
			$display("Error %0t %s got %h want %h", $time, m, got, v);
		end
	endtask

	task automatic cmp_slice(logic [65:0] v);
		chk({missv, irqv, pflags[p], pmask[p]}, v, "slice");
	endtask

	task automatic cmp_nmi(logic [65:0] v);
		chk(66'({rcsel, nreq, nflags}), v, "nmi");
	endtask

	task automatic cmp_fault(logic [65:0] v);
		chk(66'({hreq, freq, cause}), v, "fault");
	endtask

	// Oldest note is compared once its result has landed
	always begin
		@(posedge clk);
		cyc++;
		#1;
		while (q.size() > 0 && q[0].due <= cyc) begin
			case (q[0].kind)
			0: cmp_slice(q[0].v);
			1: cmp_nmi(q[0].v);
			default: cmp_fault(q[0].v);
			endcase
			void'(q.pop_front());
		end
	end

	// ****************************************************
	// Drivers
	// ****************************************************
	task automatic sstep(logic [15:0] e, logic w, logic [15:0] wv, c,
		logic m, logic [15:0] ef, em, logic emiss, eirq);
		ev[p] = e;
		cwr[p] = w;
		wdat[p] = wv;
		fclr[p] = c;
		mclr[p] = m;
		note(0, 1, {17'(emiss) << p, 17'(eirq) << p, ef, em});
		@(negedge clk);
	endtask

	task automatic slice_test();
		logic [15:0] bb, cc;
		int b;
		p = $unsigned($random(seed)) % N_PERIPH;
		b = $unsigned($random(seed)) % FLAG_W;
		bb = 16'h0001 << b;
		cc = 16'h0001 << ((b + 1) % FLAG_W);
		sstep(bb | cc, 1, 0, 0, 0, bb | cc, 0, 0, 0);
		sstep(0, 1, bb, 0, 0, bb | cc, bb, 0, 1);
		sstep(bb, 0, 0, 0, 0, bb | cc, bb, 1, 1);
		sstep(bb, 0, 0, bb, 0, bb | cc, bb, 1, 1);
		sstep(0, 1, bb | cc, ~(bb | cc), 0, bb | cc, bb | cc, 1, 1);
		sstep(0, 0, 0, bb, 0, cc, bb | cc, 1, 1);
		sstep(0, 0, 0, cc, 1, 0, bb | cc, 0, 0);
		// Strobes drop a cycle before the next slice takes over
		fclr = '0;
		mclr = '0;
		@(negedge clk);
		$display("test slice %0d bit %0d done", p, b);
	endtask

	function automatic access_t mk(logic w, pv, logic [1:0] sz, lo,
		logic ap, sy, pr, logic [11:0] off, logic tp);
		return access_t'{1'b1, w, pv, sz, lo, ap, sy, pr, off, 12'h0100, tp};
	endfunction

	task automatic facc(access_t a, logic [5:0] e);
		acc = a;
		note(2, 1, 66'(e));
		@(negedge clk);
	endtask

	task automatic fclear();
		acc = '0;
		cclr = 4'hf;
		note(2, 1, 66'h0);
		@(negedge clk);
		cclr = 4'h0;
	endtask

	task automatic stop_test();
		// A note never compared counts as a mismatch
		if (q.size() > 0) begin
			errors++;
		end
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#(5000 * 25);
		errors++;
		stop_test();
	end

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		note(0, 1, 66'h0);
		note(1, 1, 66'h0);
		note(2, 1, 66'h0);
		@(negedge clk);
		repeat (3) slice_test();
		wact = 1'b1;
		repeat (10) @(negedge clk);
		wrst = 1'b1;
		@(negedge clk);
		wrst = 1'b0;
		note(1, 19, 66'h0);
		note(1, 20, 66'h6);
		repeat (20) @(negedge clk);
		wact = 1'b0;
		nclr = 2'b10;
		note(1, 1, 66'h0);
		@(negedge clk);
		nclr = 2'b00;
		$display("test watchdog done");
		son = 1'b1;
		repeat (200) @(negedge clk);
		note(1, 1, 66'h0);
		@(negedge clk);
		run = 1'b0;
		note(1, 75, 66'h0);
		n = 0;
		while (rcsel !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		note(1, 1, 66'h8);
		n = 0;
		while (nreq !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		note(1, 1, 66'hd);
		@(negedge clk);
		nclr = 2'b01;
		note(1, 1, 66'h8);
		@(negedge clk);
		nclr = 2'b00;
		$display("test crystal done");
		facc(mk(0, 1, 2'h0, 2'h0, 1, 0, 0, 12'h0000, 0), 6'h11);
		facc(mk(0, 1, 2'h2, 2'h2, 1, 0, 0, 12'h0000, 0), 6'h39);
		fclear();
		facc(mk(1, 1, 2'h1, 2'h0, 1, 0, 0, 12'h0000, 0), 6'h11);
		fclear();
		facc(mk(1, 0, 2'h2, 2'h0, 0, 1, 0, 12'h0000, 0), 6'h12);
		fclear();
		facc(mk(1, 0, 2'h2, 2'h0, 1, 0, 1, 12'h0200, 0), 6'h16);
		fclear();
		facc(mk(0, 1, 2'h2, 2'h0, 0, 0, 0, 12'h0000, 1), 6'h14);
		fclear();
		facc(mk(1, 1, 2'h2, 2'h0, 1, 1, 1, 12'h0000, 0), 6'h00);
		facc(mk(0, 1, 2'h2, 2'h0, 1, 0, 0, 12'h0100, 0), 6'h00);
		fclear();
		$display("test bus fault done");
		// Mid-run reset must drop masks and the RC clock select
		resetn = 1'b0;
		@(negedge clk);
		resetn = 1'b1;
		note(0, 1, 66'h0);
		note(1, 1, 66'h0);
		note(2, 1, 66'h0);
		@(negedge clk);
		$display("test reset done");
		stop_test();
	end
endmodule
